/* logic/mdc_pkg.sv */
// Package: register map, field layout and serial frame constants of the motor driver config bank
package mdc_pkg;
  // Register offsets
  localparam logic [5:0] STATUS2_ADDR    = 6'h02;
  localparam logic [5:0] LOCK_ADDR       = 6'h03;
  localparam logic [5:0] DRIVE_ADDR      = 6'h04;
  localparam logic [5:0] PROT_ADDR       = 6'h05;
  localparam logic [5:0] OCP_ADDR        = 6'h06;
  localparam logic [5:0] RECT_ADDR       = 6'h07;
  localparam logic [5:0] REG_ADDR        = 6'h08;
  localparam logic [5:0] SBD_ADDR        = 6'h09;
  localparam logic [5:0] TACH_ADDR       = 6'h0a;
  localparam logic [5:0] ADV_ADDR        = 6'h0b;
  localparam logic [5:0] DLY_ADDR        = 6'h0c;
  localparam logic [5:0] LAST_ADDR       = 6'h0c;
  localparam int         NREG            = 13;
  // Reset values
  localparam logic [7:0] LOCK_RST        = 8'h00;
  localparam logic [7:0] DRIVE_RST       = 8'h80;
  localparam logic [7:0] PROT_RST        = 8'h46;
  localparam logic [7:0] OCP_RST         = 8'h10;
  localparam logic [7:0] ZERO_RST        = 8'h00;
  // Writable masks (read-as-zero bits are zero here)
  localparam logic [7:0] LOCK_WMASK      = 8'h07;
  localparam logic [7:0] DRIVE_WMASK     = 8'hfe;
  localparam logic [7:0] PROT_WMASK      = 8'h7f;
  localparam logic [7:0] FULL_WMASK      = 8'hff;
  localparam logic [7:0] REG_WMASK       = 8'h3f;
  localparam logic [7:0] SBD_WMASK       = 8'h1f;
  localparam logic [7:0] TACH_WMASK      = 8'hdf;
  localparam logic [7:0] ADV_WMASK       = 8'h07;
  localparam logic [7:0] DLY_WMASK       = 8'h1f;
  // Lock codes
  localparam logic [2:0] UNLOCK_CODE     = 3'h3;
  localparam logic [2:0] LOCK_CODE       = 3'h6;
  // Field positions
  localparam int         CLR_BIT         = 0;
  localparam int         SDO_PP_BIT      = 5;
  localparam int         CBC_BIT         = 6;
  // Status2 flag positions
  localparam int         ST_OTP          = 6;
  localparam int         ST_BOC          = 5;
  localparam int         ST_BUV          = 4;
  localparam int         ST_CPUV         = 3;
  localparam int         ST_PAR          = 2;
  localparam int         ST_FRM          = 1;
  localparam int         ST_ADR          = 0;
  // Frame layout
  localparam int         FRAME_BITS      = 16;
  localparam int         RW_BIT          = 15;
  localparam logic [4:0] FRAME_LAST      = 5'd16;

  typedef enum logic [1:0] {MDC_IDLE, MDC_SHIFT} mdc_phase_e;

  typedef struct packed {
    logic [1:0] tach_scale_select;
    logic       position_comparator_hysteresis;
    logic       brake_coasts;
    logic       freewheel;
    logic       direction_ccw;
    logic [1:0] stepdown_voltage;
    logic       stepdown_current_limit;
    logic       stepdown_disable;
    logic       stepdown_sequencing_disable;
    logic       active_async_rect_enable;
    logic       active_sync_rect_enable;
    logic       limit_recirculation_path;
    logic       power_stage_disable;
    logic       overcurrent_cycle_clear;
    logic [1:0] overcurrent_filter_time;
    logic       overcurrent_retry_time;
    logic       overcurrent_trip_level;
    logic [1:0] overcurrent_response;
    logic       full_duty_freq_sel;
    logic       supply_over_level_select;
    logic       supply_over_detect_enable;
    logic       serial_error_report_disable;
    logic       heat_warning_report_enable;
    logic [1:0] edge_rate;
    logic [1:0] drive_mode;
  } mdc_cfg_s;

  typedef struct packed {
    logic otp_err;
    logic stepdown_overcurrent_flag;
    logic stepdown_undervoltage_flag;
    logic pump_undervoltage_flag;
  } mdc_ana_s;
endpackage

/* logic/mdc_regs.sv */
// Serial-port register bank of the sensored motor driver: control fields and supply/serial status
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: Lock field code 011b unlocks; other non-lock codes leave the lock state alone.
// R2: Lock field code 110b locks; afterwards only lock field writes take effect.
// R3: Clear-fault bit clears latched faults and reads back as zero.
// R4: Drive register bit 5 picks open-drain (0) or push-pull (1) serial output.
// R5: Two-bit edge-rate field, 25/50/125/200 V/us, passed to gate drive.
// R6: Two-bit drive mode: async/sync rectification, analog/digital sensors.
// R7: One bit chooses full-duty switching frequency 20 kHz or 40 kHz.
// R8: Overvoltage enable resets to 1; select bit picks 34 V or 22 V.
// R9: Serial faults reach fault pin when disable bit 0; warnings when report bit 1.
// R10: Driver-off bit forces all switches high-impedance; clearing it does nothing more.
// R11: Cycle-clear bit set: overcurrent clears at next input cycle change.
// R12: Overcurrent deglitch 0.2/0.6/1.2/1.6 us by code; resets to code 1.
// R13: Overcurrent code 0 latches, code 1 retries after 5 or 500 ms.
// R14: Overcurrent trip level 9 A or 13 A by one bit.
// R15: Current-limit recirculation via transistors (0) or diodes (1).
// R16: Bit 3 enables active async rectification, bit 2 active sync.
// R17: Step-down voltage, current limit, disable and sequencing-disable fields.
// R18: Position comparator hysteresis 5 mV or 50 mV.
// R19: Freewheel bit enables coast; brake-behaviour bit brakes (0) or coasts (1).
// R20: Rotation bit: clockwise (0) or anti-clockwise (1) commutation.
// R21: Tach scale 3x, 1x, 0.5x or 0.25x of commutation frequency.
// R22: Status register reports memory, regulator, pump and serial error flags.
// R23: Frame is 16 bits: rw, six-bit address, even parity, eight data, MSB first.
// R24: All registers return to defaults at power-up and on sleep entry.
// R25: Access to an address above 0xC sets the bad-address flag.
// R26: Latched serial flags hold until clear-fault write or sleep reset.
// R27: Read-as-zero reserved fields read zero and ignore writes.
module mdc_regs (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  // Sleep pin, active low
  input  wire logic                sleep_pin_n_i,
  // Serial port pins
  input  wire logic                serial_sel_n_i,
  input  wire logic                serial_clk_i,
  input  wire logic                serial_in_i,
  output logic                     serial_out_o,
  output logic                     serial_out_oe_o,
  // Fault sources from the analog side
  input  wire mdc_pkg::mdc_ana_s   ana_flags_i,
  input  wire logic                heat_warning_i,
  // Configuration to the power stage
  output mdc_pkg::mdc_cfg_s        cfg_o,
  output logic                     fault_clear_pulse_o,
  output logic                     fault_output_pin_n_o
);

  typedef struct packed {
    logic [2:0]               sel_sync;
    logic [2:0]               clk_sync;
    logic [1:0]               din_sync;
    logic [1:0]               slp_sync;
    mdc_pkg::mdc_ana_s [1:0]  ana_sync;
    logic [1:0]               heat_sync;
    logic                     sel_act;
    mdc_pkg::mdc_phase_e      phase;
    logic [4:0]               cnt;
    logic [15:0]              sh_in;
    logic [15:0]              sh_out;
    logic                     out_bit;
    logic                     out_oe;
    logic                     locked;
    logic [mdc_pkg::NREG-1:0][7:0] regs;
    logic                     f_par;
    logic                     f_frm;
    logic                     f_adr;
    logic                     clr_pulse;
    logic                     fault_n;
  } mdc_state_s;

  mdc_state_s s_q;
  mdc_state_s s_d;

  logic [mdc_pkg::NREG-1:0][7:0] rst_vals;
  logic [mdc_pkg::NREG-1:0][7:0] wmask;

  // Per-register reset value and writable mask; status registers are not writable
  genvar gi;
  generate
    for (gi = 0; gi < mdc_pkg::NREG; gi++) begin : g_map
      always_comb begin
        case (6'(gi))
          mdc_pkg::LOCK_ADDR:  begin rst_vals[gi] = mdc_pkg::LOCK_RST;  wmask[gi] = mdc_pkg::LOCK_WMASK;  end
          mdc_pkg::DRIVE_ADDR: begin rst_vals[gi] = mdc_pkg::DRIVE_RST; wmask[gi] = mdc_pkg::DRIVE_WMASK; end
          mdc_pkg::PROT_ADDR:  begin rst_vals[gi] = mdc_pkg::PROT_RST;  wmask[gi] = mdc_pkg::PROT_WMASK;  end
          mdc_pkg::OCP_ADDR:   begin rst_vals[gi] = mdc_pkg::OCP_RST;   wmask[gi] = mdc_pkg::FULL_WMASK;  end
          mdc_pkg::RECT_ADDR:  begin rst_vals[gi] = mdc_pkg::ZERO_RST;  wmask[gi] = mdc_pkg::FULL_WMASK;  end
          mdc_pkg::REG_ADDR:   begin rst_vals[gi] = mdc_pkg::ZERO_RST;  wmask[gi] = mdc_pkg::REG_WMASK;   end
          mdc_pkg::SBD_ADDR:   begin rst_vals[gi] = mdc_pkg::ZERO_RST;  wmask[gi] = mdc_pkg::SBD_WMASK;   end
          mdc_pkg::TACH_ADDR:  begin rst_vals[gi] = mdc_pkg::ZERO_RST;  wmask[gi] = mdc_pkg::TACH_WMASK;  end
          mdc_pkg::ADV_ADDR:   begin rst_vals[gi] = mdc_pkg::ZERO_RST;  wmask[gi] = mdc_pkg::ADV_WMASK;   end
          mdc_pkg::DLY_ADDR:   begin rst_vals[gi] = mdc_pkg::ZERO_RST;  wmask[gi] = mdc_pkg::DLY_WMASK;   end
          default:             begin rst_vals[gi] = mdc_pkg::ZERO_RST;  wmask[gi] = mdc_pkg::ZERO_RST;    end
        endcase
      end
    end
  endgenerate

  logic       sel_n;
  logic       sel_rise;
  logic       sel_fall;
  logic       clk_rise;
  logic       clk_fall;
  logic       sleep_enter;
  logic [15:0] frame;
  logic [5:0] addr;
  logic       addr_ok;
  logic [7:0] cur_val;
  logic [7:0] status2;
  logic       parity_ok;
  logic       is_write;
  logic       serial_err;
  logic [5:0] raddr;
  logic       frame_done;
  logic       wr_ok;

  always_comb begin
    sel_n       = s_q.sel_sync[1];
    sel_rise    = s_q.sel_sync[1] & ~s_q.sel_sync[2];
    sel_fall    = ~s_q.sel_sync[1] & s_q.sel_sync[2];
    clk_rise    = s_q.clk_sync[1] & ~s_q.clk_sync[2];
    clk_fall    = ~s_q.clk_sync[1] & s_q.clk_sync[2];
    sleep_enter = ~s_q.slp_sync[1];
    frame       = s_q.sh_in;
    addr        = frame[14:9];
    addr_ok     = addr <= mdc_pkg::LAST_ADDR;                                 // R25
    parity_ok   = ~(^frame);                                                  // R23
    is_write    = ~frame[mdc_pkg::RW_BIT];
    status2     = {1'b0, s_q.ana_sync[1],
                   s_q.f_par, s_q.f_frm, s_q.f_adr};                          // R22
    // Mid-frame the address sits in the low shift bits, not at its final place
    raddr       = s_q.sh_in[5:0];
    cur_val     = 8'h00;
    if (raddr == mdc_pkg::STATUS2_ADDR) begin
      cur_val = status2;
    end else if (raddr <= mdc_pkg::LAST_ADDR) begin
      cur_val = s_q.regs[raddr[3:0]];
    end
    serial_err  = s_q.f_par | s_q.f_frm | s_q.f_adr;
    frame_done  = s_q.phase == mdc_pkg::MDC_SHIFT && sel_rise && !sleep_enter;
    wr_ok       = frame_done && s_q.cnt == mdc_pkg::FRAME_LAST && addr_ok && parity_ok && is_write;
  end

  always_comb begin
    logic [7:0] wdata;
    wdata = 8'h00;
    s_d = s_q;
    s_d.sel_sync  = {s_q.sel_sync[1:0], serial_sel_n_i};
    s_d.clk_sync  = {s_q.clk_sync[1:0], serial_clk_i};
    s_d.din_sync  = {s_q.din_sync[0], serial_in_i};
    s_d.slp_sync  = {s_q.slp_sync[0], sleep_pin_n_i};
    s_d.ana_sync  = {s_q.ana_sync[0], ana_flags_i};
    s_d.heat_sync = {s_q.heat_sync[0], heat_warning_i};
    s_d.clr_pulse = 1'b0;

    case (s_q.phase)
      mdc_pkg::MDC_IDLE: begin
        if (sel_fall) begin
          s_d.phase  = mdc_pkg::MDC_SHIFT;
          s_d.cnt    = 5'd0;
          s_d.sh_out = {8'h00, 8'h00};
          s_d.sel_act = 1'b1;
          s_d.out_bit = 1'b0;
        end
      end
      mdc_pkg::MDC_SHIFT: begin
        // Capture on falling, launch on rising clock
        if (clk_fall) begin
          s_d.sh_in = {s_q.sh_in[14:0], s_q.din_sync[1]};                     // R23
          if (s_q.cnt != 5'h1f) begin
            s_d.cnt = s_q.cnt + 5'd1;
          end
          // As the last address bit is captured, zero the low byte of the reply shifter
          if (s_q.cnt == 5'd6) begin
            s_d.sh_out[7:0] = 8'h00;
          end
        end
        if (clk_rise) begin
          s_d.out_bit = s_q.sh_out[15];
          s_d.sh_out  = {s_q.sh_out[14:0], 1'b0};
        end
        if (sel_rise) begin
          s_d.phase  = mdc_pkg::MDC_IDLE;
          s_d.sel_act = 1'b0;
          if (s_q.cnt != mdc_pkg::FRAME_LAST) begin
            s_d.f_frm = 1'b1;                                                 // R23
          end else if (!addr_ok) begin
            s_d.f_adr = 1'b1;                                                 // R25
          end else if (!parity_ok) begin
            s_d.f_par = 1'b1;
          end else if (is_write) begin
            wdata = frame[7:0];
            if (addr == mdc_pkg::LOCK_ADDR) begin
              if (wdata[2:0] == mdc_pkg::UNLOCK_CODE) begin
                s_d.locked = 1'b0;                                            // R1
              end else if (wdata[2:0] == mdc_pkg::LOCK_CODE) begin
                s_d.locked = 1'b1;                                            // R2
              end
              s_d.regs[addr[3:0]] = wdata & mdc_pkg::LOCK_WMASK;              // R27
            end else if (!s_q.locked) begin                                   // R2
              s_d.regs[addr[3:0]] = wdata & wmask[addr[3:0]];                 // R27
              if (addr == mdc_pkg::DRIVE_ADDR && wdata[mdc_pkg::CLR_BIT]) begin
                s_d.clr_pulse = 1'b1;                                         // R3
              end
            end
          end
        end
      end
      default: s_d.phase = mdc_pkg::MDC_IDLE;
    endcase

    // Reply byte: current content, loaded once the address is known
    if (s_q.phase == mdc_pkg::MDC_SHIFT && s_q.cnt == 5'd7 && clk_rise) begin
      s_d.sh_out = {cur_val, 8'h00};
    end

    // Clear after set so a new flag in the same cycle survives
    if (s_q.clr_pulse) begin                                                  // R26
      s_d.f_par = s_d.f_par & ~(s_q.f_par);
      s_d.f_frm = s_d.f_frm & ~(s_q.f_frm);
      s_d.f_adr = s_d.f_adr & ~(s_q.f_adr);
      if (s_q.phase == mdc_pkg::MDC_SHIFT && sel_rise) begin
        s_d.f_par = s_d.f_par | (s_q.cnt == mdc_pkg::FRAME_LAST && addr_ok && !parity_ok);
        s_d.f_frm = s_d.f_frm | (s_q.cnt != mdc_pkg::FRAME_LAST);
        s_d.f_adr = s_d.f_adr | (s_q.cnt == mdc_pkg::FRAME_LAST && !addr_ok);
      end
    end

    // Fault pin is active low; each source has its own report control
    s_d.fault_n = ~((serial_err & ~s_q.regs[mdc_pkg::PROT_ADDR[3:0]][1])     // R9
                  | (s_q.heat_sync[1] & s_q.regs[mdc_pkg::PROT_ADDR[3:0]][0]));

    if (sleep_enter) begin                                                    // R24
      s_d.regs   = rst_vals;
      s_d.locked = 1'b0;
      s_d.f_par  = 1'b0;
      s_d.f_frm  = 1'b0;
      s_d.f_adr  = 1'b0;
      s_d.phase  = mdc_pkg::MDC_IDLE;
      s_d.sel_act = 1'b0;
    end

    // Open drain releases the line for a one; push-pull drives both levels
    s_d.out_oe = s_d.sel_act
               & (s_d.regs[mdc_pkg::DRIVE_ADDR[3:0]][mdc_pkg::SDO_PP_BIT] | ~s_d.out_bit); // R4
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin                                                          // R24
      s_q          <= '0;
      s_q.sel_sync <= 3'h7;
      s_q.slp_sync <= 2'h3;
      s_q.fault_n  <= 1'b1;
      s_q.regs[mdc_pkg::DRIVE_ADDR[3:0]] <= mdc_pkg::DRIVE_RST;
      s_q.regs[mdc_pkg::PROT_ADDR[3:0]]  <= mdc_pkg::PROT_RST;
      s_q.regs[mdc_pkg::OCP_ADDR[3:0]]   <= mdc_pkg::OCP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  logic [7:0] r_drv;
  logic [7:0] r_prt;
  logic [7:0] r_ocp;
  logic [7:0] r_rec;
  logic [7:0] r_reg;
  logic [7:0] r_sbd;
  logic [7:0] r_tch;

  always_comb begin
    r_drv = s_q.regs[mdc_pkg::DRIVE_ADDR[3:0]];
    r_prt = s_q.regs[mdc_pkg::PROT_ADDR[3:0]];
    r_ocp = s_q.regs[mdc_pkg::OCP_ADDR[3:0]];
    r_rec = s_q.regs[mdc_pkg::RECT_ADDR[3:0]];
    r_reg = s_q.regs[mdc_pkg::REG_ADDR[3:0]];
    r_sbd = s_q.regs[mdc_pkg::SBD_ADDR[3:0]];
    r_tch = s_q.regs[mdc_pkg::TACH_ADDR[3:0]];
  end

  // Configuration fields come straight from register flops
  assign cfg_o.edge_rate                      = r_drv[4:3];                   // R5
  assign cfg_o.drive_mode                     = r_drv[2:1];                   // R6
  assign cfg_o.full_duty_freq_sel             = r_prt[4];                     // R7
  assign cfg_o.supply_over_level_select       = r_prt[3];                     // R8
  assign cfg_o.supply_over_detect_enable      = r_prt[2];                     // R8
  assign cfg_o.serial_error_report_disable    = r_prt[1];
  assign cfg_o.heat_warning_report_enable     = r_prt[0];
  assign cfg_o.power_stage_disable            = r_ocp[7];                     // R10
  assign cfg_o.overcurrent_cycle_clear        = r_ocp[mdc_pkg::CBC_BIT];      // R11
  assign cfg_o.overcurrent_filter_time        = r_ocp[5:4];                   // R12
  assign cfg_o.overcurrent_retry_time         = r_ocp[3];                     // R13
  assign cfg_o.overcurrent_trip_level         = r_ocp[2];                     // R14
  assign cfg_o.overcurrent_response           = r_ocp[1:0];                   // R13
  assign cfg_o.limit_recirculation_path       = r_rec[6];                     // R15
  assign cfg_o.active_async_rect_enable       = r_rec[3];                     // R16
  assign cfg_o.active_sync_rect_enable        = r_rec[2];                     // R16
  assign cfg_o.stepdown_sequencing_disable    = r_reg[4];                     // R17
  assign cfg_o.stepdown_current_limit         = r_reg[3];                     // R17
  assign cfg_o.stepdown_voltage               = r_reg[2:1];                   // R17
  assign cfg_o.stepdown_disable               = r_reg[0];                     // R17
  assign cfg_o.position_comparator_hysteresis = r_sbd[4];                     // R18
  assign cfg_o.brake_coasts                   = r_sbd[3];                     // R19
  assign cfg_o.freewheel                      = r_sbd[2];                     // R19
  assign cfg_o.direction_ccw                  = r_sbd[0];                     // R20
  assign cfg_o.tach_scale_select              = r_tch[7:6];                   // R21

  assign fault_clear_pulse_o  = s_q.clr_pulse;                                // R3
  assign fault_output_pin_n_o = s_q.fault_n;
  assign serial_out_o         = s_q.out_bit;
  // Enable is registered alongside the bit it qualifies
  assign serial_out_oe_o      = s_q.out_oe;                                   // R4

  a_clear_self: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_q.clr_pulse |=> !s_q.clr_pulse)
    else $error("clear pulse lasted more than one cycle"); // R3
  a_clear_bit_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    r_drv[mdc_pkg::CLR_BIT] == 1'b0)
    else $error("clear-fault bit stored as one"); // R3
  a_lock_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_q.locked && !sleep_enter) |=> $stable(r_ocp))
    else $error("locked register changed"); // R2
  a_sleep_defaults: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sleep_enter |=> (r_prt == mdc_pkg::PROT_RST && r_ocp == mdc_pkg::OCP_RST && !s_q.locked))
    else $error("sleep did not restore defaults"); // R24
  a_lock_rsvd_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_q.regs[mdc_pkg::LOCK_ADDR[3:0]][7:3] == 5'h00 && r_sbd[7:5] == 3'h0)
    else $error("read-as-zero bits set"); // R27
  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_q.f_adr && !s_q.clr_pulse && !sleep_enter) |=> s_q.f_adr)
    else $error("address flag dropped without clear"); // R26
  a_bad_addr_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_q.phase == mdc_pkg::MDC_SHIFT && sel_rise && s_q.cnt == mdc_pkg::FRAME_LAST && !addr_ok
     && !sleep_enter) |=> s_q.f_adr)
    else $error("bad address not flagged"); // R25
  a_frame_short: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_q.phase == mdc_pkg::MDC_SHIFT && sel_rise && s_q.cnt != mdc_pkg::FRAME_LAST && !sleep_enter)
    |=> s_q.f_frm)
    else $error("short frame not flagged"); // R23
  a_fault_report: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_q.f_frm && !r_prt[1]) |=> !s_q.fault_n)
    else $error("serial fault not reported on fault pin"); // R9
  a_od_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!r_drv[mdc_pkg::SDO_PP_BIT] && s_q.out_bit) |-> !serial_out_oe_o)
    else $error("open drain drove a one"); // R4
  a_unlock_code: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_ok && addr == mdc_pkg::LOCK_ADDR && frame[2:0] == mdc_pkg::UNLOCK_CODE) |=> !s_q.locked)
    else $error("unlock code did not unlock"); // R1
  a_lock_code: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_ok && addr == mdc_pkg::LOCK_ADDR && frame[2:0] == mdc_pkg::LOCK_CODE) |=> s_q.locked)
    else $error("lock code did not lock"); // R2
  a_lock_other: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (wr_ok && addr == mdc_pkg::LOCK_ADDR && frame[2:0] != mdc_pkg::UNLOCK_CODE
     && frame[2:0] != mdc_pkg::LOCK_CODE) |=> $stable(s_q.locked))
    else $error("other lock code changed lock state"); // R1
  a_clear_flags: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_q.clr_pulse && !frame_done && !sleep_enter) |=> !serial_err)
    else $error("clear pulse left a serial flag set"); // R3
  a_parity_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (frame_done && s_q.cnt == mdc_pkg::FRAME_LAST && addr_ok && !parity_ok) |=> s_q.f_par)
    else $error("parity error not flagged"); // R23
  a_idle_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_q.phase == mdc_pkg::MDC_IDLE) |-> !serial_out_oe_o)
    else $error("serial output driven while deselected"); // R23
  a_heat_report: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_q.heat_sync[1] && r_prt[0]) |=> !s_q.fault_n)
    else $error("heat warning not reported on fault pin"); // R9

endmodule
`default_nettype wire

/* tb/mdc_spi_host.sv */
// Serial port controller model that sends frames to the register bank
`timescale 1ns/100ps
`default_nettype none
module mdc_spi_host (
  // Clock
  input  wire logic clk_i,
  // Serial pins
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b0;
    sdi_o   = 1'b0;
  end
  // Half of the 64 ns link period is four reference cycles
  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask
  // Reply is sampled late in the low phase, before the next launching rise
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    sel_n_o <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'b1;
      sdi_o  <= w[15 - (i % 16)];
      half();
      sclk_o <= 1'b0;
      half();
      r = {r[14:0], sdo_i};
    end
    sdi_o   <= ~sdi_o;
    sel_n_o <= 1'b1;
    repeat (60) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* tb/tb_mdc_regs.sv */
// Self-checking bench of the register bank against a behavioural register model
`timescale 1ns/100ps
`default_nettype none
module tb_mdc_regs;
  logic              ref_clk_i = 1'b0;
  logic              rst_i     = 1'b1;
  logic              sleep_n   = 1'b1;
  logic              heat      = 1'b0;
  logic              sel_n, sclk, sdi, sdo, sdo_oe, clr_p, fault_n, sdo_line, locked;
  mdc_pkg::mdc_ana_s ana       = '0;
  mdc_pkg::mdc_cfg_s cfg;
  logic [7:0]        rm [13];
  logic [2:0]        flt;
  int                error_cnt = 0, total_checks = 0, pulses = 0, exp_pulses = 0, pp_hi = 0;
  // Open-drain line with a pull-up
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  mdc_regs mdc_regs_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sleep_pin_n_i(sleep_n), .serial_sel_n_i(sel_n),
    .serial_clk_i(sclk), .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe), .ana_flags_i(ana),
    .heat_warning_i(heat), .cfg_o(cfg), .fault_clear_pulse_o(clr_p), .fault_output_pin_n_o(fault_n));
  mdc_spi_host mdc_spi_host_inst (.clk_i(ref_clk_i), .sel_n_o(sel_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo_line));
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (clr_p === 1'b1) pulses++;
    if (sdo_oe === 1'b1 && sdo === 1'b1) pp_hi++;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic mreset();
    foreach (rm[i]) rm[i] = 8'h00;
    rm[4]  = mdc_pkg::DRIVE_RST;
    rm[5]  = mdc_pkg::PROT_RST;
    rm[6]  = mdc_pkg::OCP_RST;
    flt    = '0;
    locked = 1'b0;
  endtask
  function automatic logic [7:0] wmask(input logic [5:0] a);
    case (a)
      6'h04: return mdc_pkg::DRIVE_WMASK;
      6'h05: return mdc_pkg::PROT_WMASK;
      6'h08: return mdc_pkg::REG_WMASK;
      6'h09: return mdc_pkg::SBD_WMASK;
      6'h0a: return mdc_pkg::TACH_WMASK;
      6'h0b: return mdc_pkg::ADV_WMASK;
      6'h0c: return mdc_pkg::DLY_WMASK;
      default: return mdc_pkg::FULL_WMASK;
    endcase
  endfunction
  task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d, input int n = 16,
                      input logic bad = 1'b0);
    logic [15:0] w;
    logic [15:0] r;
    w    = {rd, a, 1'b0, d};
    w[8] = (^w) ^ bad;
    mdc_spi_host_inst.frame(w, n, r);
    if (n == 16 && !bad && a >= 6'h02 && a <= 6'h0c) begin
      check("reply status", r[15:8], 8'h00);
      check("reply data", r[7:0], a == 6'h02 ? {1'b0, ana, flt} : rm[a]);
    end
    if (n != 16) flt[1] = 1'b1;
    else if (bad) flt[2] = 1'b1;
    else if (a > 6'h0c) flt[0] = 1'b1;
    else if (!rd && a == 6'h03) begin
      rm[3] = d & mdc_pkg::LOCK_WMASK;
      if (d[2:0] == 3'h3) locked = 1'b0;
      if (d[2:0] == 3'h6) locked = 1'b1;
    end else if (!rd && a > 6'h03 && !locked) begin
      rm[a] = d & wmask(a);
      if (a == 6'h04 && d[0]) begin
        flt = '0;
        exp_pulses++;
      end
    end
    check("config", cfg, {rm[10][7:6], rm[9][4:2], rm[9][0], rm[8][2:1], rm[8][3], rm[8][0], rm[8][4], rm[7][3:2],
      rm[7][6], rm[6], rm[5][4:0], rm[4][4:1]});
    if (ana == '0) check("fault pin", fault_n, !((|flt && !rm[5][1]) || (heat && rm[5][0])));
    check("clear pulses", pulses, exp_pulses);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h9083538f));
    mreset();
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    for (int a = 2; a <= 12; a++) xfer(1'b1, 6'(a), 8'h00);
    check("open drain", pp_hi, 0);
    xfer(1'b0, 6'h04, 8'h20);
    xfer(1'b1, 6'h04, 8'h00);
    check("push pull", pp_hi != 0, 1);
    $display("test reset_and_driver done");
    repeat (2) for (int a = 3; a <= 12; a++) xfer(1'b0, 6'(a), 8'($urandom));
    xfer(1'b0, 6'h03, 8'h03);
    for (int a = 3; a <= 12; a++) xfer(1'b1, 6'(a), 8'h00);
    $display("test random_fields done");
    for (int c = 0; c < 8; c++) begin
      xfer(1'b0, 6'h03, 8'(c));
      xfer(1'b0, 6'h07, 8'($urandom));
    end
    xfer(1'b0, 6'h03, 8'h03);
    xfer(1'b0, 6'h06, 8'ha5);
    $display("test lock_codes done");
    xfer(1'b0, 6'h05, 8'h44);
    xfer(1'b1, 6'h0d, 8'h00);
    xfer(1'b0, 6'h04, 8'h33, 15);
    xfer(1'b0, 6'h04, 8'h33, 16, 1'b1);
    ana <= 4'($urandom);
    xfer(1'b1, 6'h02, 8'h00);
    ana <= '0;
    xfer(1'b0, 6'h04, 8'h01);
    xfer(1'b1, 6'h02, 8'h00);
    heat <= 1'b1;
    xfer(1'b0, 6'h05, 8'h01);
    xfer(1'b0, 6'h05, 8'h02);
    heat <= 1'b0;
    $display("test faults done");
    xfer(1'b1, 6'h3f, 8'h00);
    sleep_n <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    sleep_n <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    mreset();
    for (int a = 2; a <= 12; a++) xfer(1'b1, 6'(a), 8'h00);
    $display("test sleep done");
    complete_run();
  end
endmodule
`default_nettype wire
